//--- dqr_host.sv
`timescale 1ns/1ps
module dqr_host (
    input  wire logic       aclk,
    output logic            sck,
    output logic            sel_n,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe_n
);
    logic [3:0] sq[$];
    logic [3:0] oq[$];
    int         dbase;
    initial begin
        {sck, sel_n, io_in} = 6'h10;
    end
    // half period of 8 aclk keeps sck far below 66 MHz
    task automatic half(input logic [3:0] nib, input logic drv, input logic lvl);
        repeat (4) @(posedge aclk);
        // released lanes follow the device or toggle
        io_in <= drv ? nib : (~io_oe_n & io_out) | (io_oe_n & ~io_in);
        repeat (3) @(posedge aclk);
        #1;
        sq.push_back(io_out); // one fixed capture point
        oq.push_back(io_oe_n);
        @(posedge aclk);
        sck <= lvl;
    endtask
    // one access, select low from opcode through mode, dummy and data
    task automatic frame(input logic cmd, input logic fw, input logic [7:0] op,
                         input logic [31:0] adr, input int na, input logic [7:0] md,
                         input int lat, input int nb);
        logic [3:0] n;
        int         i;
        sq.delete();
        oq.delete();
        @(posedge aclk);
        sel_n <= 1'b0;
        for (i = 0; cmd && i < (fw ? 2 : 8); i++) begin
            n = fw ? op[7-4*i -: 4] : {3'h0, op[7-i]};
            half(n, 1'b1, 1'b1);
            half(n, 1'b1, 1'b0);
        end
        for (i = 0; i < na; i++) half(adr[4*na-1-4*i -: 4], 1'b1, i % 2 == 0);
        half(md[7:4], 1'b1, 1'b1);
        half(md[3:0], 1'b1, 1'b0);
        dbase = sq.size();
        for (i = 0; i < 2 * (lat + nb); i++) half(4'h0, 1'b0, i % 2 == 0);
        repeat (8) @(posedge aclk);
        sel_n <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask
endmodule

//--- dqr_mem.sv
`timescale 1ns/1ps
module dqr_mem #(
    parameter int AW = 24,
    parameter int DW = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(2**AW)-1];
    logic [DW-1:0] rd_ff;

    // array write, no reset on contents
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read, one cycle behind the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= mem[rd_addr];
        end
    end

    assign rd_data = rd_ff;
endmodule

//--- dqr_pkg.sv
package dqr_pkg;
    // register bus geometry and offsets
    localparam int            AXI_AW     = 8;
    localparam logic [7:0]    OFF_CFG1   = 8'h00;
    localparam logic [7:0]    OFF_CFG2   = 8'h04;
    localparam logic [7:0]    OFF_CFG3   = 8'h08;
    localparam logic [7:0]    OFF_PAT    = 8'h0C;
    localparam logic [7:0]    OFF_PTR    = 8'h10;
    localparam logic [7:0]    OFF_WDAT   = 8'h14;
    localparam logic [7:0]    OFF_STAT   = 8'h18;
    localparam logic [7:0]    OFF_ADDR   = 8'h1C;
    // field positions
    localparam int            CFG1_QUAD  = 1;
    localparam int            CFG2_ALEN  = 0;
    localparam int            CFG2_FWCM  = 3;
    localparam int            CFG3_TRAIN = 4;
    localparam int            LAT_W      = 4;
    // reset values
    localparam logic [7:0]    CFG1_RST   = 8'h00;
    localparam logic [7:0]    CFG2_RST   = 8'h00;
    localparam logic [7:0]    CFG3_RST   = 8'h00;
    localparam logic [7:0]    PAT_RST    = 8'h34;
    // opcodes
    localparam logic [7:0]    OP_READ3   = 8'hED;
    localparam logic [7:0]    OP_READ4   = 8'hEE;
    localparam logic [7:0]    OP_MODE_RST = 8'hFF;
    // last index of the command and address phases; preamble length in edges
    localparam logic [3:0]    CMD_LAST_SER = 4'h7;
    localparam logic [3:0]    CMD_LAST_FW  = 4'h1;
    localparam logic [3:0]    ADDR_LAST3   = 4'h5;
    localparam logic [3:0]    ADDR_LAST4   = 4'h7;
    localparam logic [4:0]    TRAIN_EDGES  = 5'h08;
    // bus answers
    localparam logic [1:0]    RESP_OKAY   = 2'h0;
    localparam logic [1:0]    RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_MODE  = 3'b011,
        ST_DUMMY = 3'b100,
        ST_DATA  = 3'b101,
        ST_SKIP  = 3'b110
    } dqr_state_t;

    // nibbles that are bitwise complements
    function automatic logic dqr_cplx(input logic [3:0] hi, input logic [3:0] lo);
        return hi == ~lo;
    endfunction

    // low byte lane merge for the narrow registers
    function automatic logic [7:0] dqr_merge(input logic [7:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
        return strb[0] ? wd[7:0] : old;
    endfunction

    function automatic logic dqr_hit(input logic [AXI_AW-1:0] a);
        return a == OFF_CFG1 || a == OFF_CFG2 || a == OFF_CFG3 || a == OFF_PAT
            || a == OFF_PTR || a == OFF_WDAT || a == OFF_STAT || a == OFF_ADDR;
    endfunction
endpackage

//--- dqr_top.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - read accepted only with quad or four-wire enable (code checks it only in the opcode phase, which continuous mode skips)
// - EDh address length per bit, EEh four bytes
// - address nibbles sampled on both clock edges
// - data out four bits every clock edge
// - dummy cycles from latency field, lanes ignored
// - complementary mode nibbles enter continuous mode
// - non-complementary mode leaves at next select boundary
// - mode reset command leaves continuous mode (code decodes it only in the opcode phase, which continuous mode skips)
// - any start byte, address steps per byte
// - address wraps to zero past top
// - pattern drives last four dummy cycles
// - same programmable pattern on all lanes
// - four-wire mode: opcode nibble per rising edge
// - otherwise opcode eight serial rising-edge bits
module dqr_top
    import dqr_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [AXI_AW-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [AXI_AW-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              sck,
    input  wire logic              sel_n,
    input  wire logic [3:0]        io_in,
    output logic [3:0]             io_out,
    output logic [3:0]             io_oe_n
);
    logic              sck_m_ff, sck_s_ff, sck_d_ff;
    logic              cs_m_ff, cs_s_ff, cs_d_ff;
    logic [3:0]        io_m_ff, io_s_ff;
    logic              sck_rise, sck_fall, cs_rise, cs_fall, addr_take;
    dqr_state_t        state_ff;
    logic [3:0]        cnt_ff, cmd_last, addr_last, mhi_ff;
    logic [7:0]        cmd_sh_ff, nxt_cmd;
    logic [31:0]       ash_ff, nxt_ash;
    logic              a4_ff, pend_ff, mode_done_ff, cont_ff;
    logic [4:0]        dcnt_ff;
    logic [ADDR_W-1:0] addr_ff, ptr_ff, mem_wa_ff;
    logic [7:0]        byte_ff, mem_rd, mem_wd_ff;
    logic              mem_we_ff;
    logic [3:0]        io_out_ff, io_oe_n_ff;
    logic [7:0]        cfg1_ff, cfg2_ff, cfg3_ff, pat_ff;
    logic              quad_en, fw_mode, train_en, pat_bit;
    logic [LAT_W-1:0]  lat;
    logic              aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff, wr_fire;
    logic [AXI_AW-1:0] awaddr_ff;
    logic [31:0]       wdata_ff, rdata_ff, rd_mux;
    logic [3:0]        wstrb_ff;
    logic [1:0]        bresp_ff, rresp_ff;
    logic              arready_ff, rvalid_ff;

    // two-stage pin synchronisers plus a third stage for edge finding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_m_ff <= 1'b0;
            sck_s_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            cs_m_ff  <= 1'b1;
            cs_s_ff  <= 1'b1;
            cs_d_ff  <= 1'b1;
            io_m_ff  <= 4'h0;
            io_s_ff  <= 4'h0;
        end else begin
            sck_m_ff <= sck;
            sck_s_ff <= sck_m_ff;
            sck_d_ff <= sck_s_ff;
            cs_m_ff  <= sel_n;
            cs_s_ff  <= cs_m_ff;
            cs_d_ff  <= cs_s_ff;
            io_m_ff  <= io_in;
            io_s_ff  <= io_m_ff;
        end
    end

    // edges and decoded configuration
    assign sck_rise  = sck_s_ff & ~sck_d_ff;
    assign sck_fall  = ~sck_s_ff & sck_d_ff;
    assign cs_rise   = cs_s_ff & ~cs_d_ff;
    assign cs_fall   = ~cs_s_ff & cs_d_ff;
    assign quad_en   = cfg1_ff[CFG1_QUAD] | cfg2_ff[CFG2_FWCM];
    assign fw_mode   = cfg2_ff[CFG2_FWCM];
    assign train_en  = cfg3_ff[CFG3_TRAIN];
    assign lat       = cfg3_ff[LAT_W-1:0];
    assign cmd_last  = fw_mode ? CMD_LAST_FW : CMD_LAST_SER;
    assign addr_last = a4_ff ? ADDR_LAST4 : ADDR_LAST3;
    assign nxt_cmd   = fw_mode ? {cmd_sh_ff[3:0], io_s_ff} : {cmd_sh_ff[6:0], io_s_ff[0]};
    assign nxt_ash   = {ash_ff[27:0], io_s_ff};
    assign pat_bit   = pat_ff[3'(dcnt_ff - 5'h01)];
    // first address nibble waits for a rising edge; a stray falling edge
    // right after the last opcode bit must not be taken as address
    assign addr_take = (state_ff == ST_ADDR) && !cs_rise && !cs_fall
                       && (sck_rise || (sck_fall && cnt_ff != 4'h0));

    // access sequencer: phases, counters, continuous-mode flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 4'h0;
            cmd_sh_ff    <= 8'h00;
            ash_ff       <= 32'h0000_0000;
            a4_ff        <= 1'b0;
            mhi_ff       <= 4'h0;
            pend_ff      <= 1'b0;
            mode_done_ff <= 1'b0;
            cont_ff      <= 1'b0;
            dcnt_ff      <= 5'h00;
        end else if (cs_rise) begin
            state_ff     <= ST_IDLE;
            mode_done_ff <= 1'b0;
            if (mode_done_ff) begin
                cont_ff <= pend_ff;
            end
        end else if (cs_fall) begin
            state_ff  <= cont_ff ? ST_ADDR : ST_CMD;
            cnt_ff    <= 4'h0;
            cmd_sh_ff <= 8'h00;
            ash_ff    <= 32'h0000_0000;
        end else begin
            case (state_ff)
                ST_CMD: begin
                    if (sck_rise) begin
                        cmd_sh_ff <= nxt_cmd;
                        cnt_ff    <= cnt_ff + 4'h1;
                        if (cnt_ff == cmd_last) begin
                            cnt_ff <= 4'h0;
                            if ((nxt_cmd == OP_READ3 || nxt_cmd == OP_READ4) && quad_en) begin
                                state_ff <= ST_ADDR;
                                a4_ff    <= (nxt_cmd == OP_READ4) | cfg2_ff[CFG2_ALEN];
                            end else begin
                                state_ff <= ST_SKIP;
                                if (nxt_cmd == OP_MODE_RST) begin
                                    cont_ff <= 1'b0;
                                end
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_take) begin
                        ash_ff <= nxt_ash;
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == addr_last) begin
                            cnt_ff   <= 4'h0;
                            state_ff <= ST_MODE;
                        end
                    end
                end
                ST_MODE: begin
                    if (sck_rise) begin
                        mhi_ff <= io_s_ff;
                    end else if (sck_fall) begin
                        pend_ff      <= dqr_cplx(mhi_ff, io_s_ff);
                        mode_done_ff <= 1'b1;
                        state_ff     <= ST_DUMMY;
                        dcnt_ff      <= {1'b0, lat} << 1;
                    end
                end
                ST_DUMMY: begin
                    // counts half cycles so the preamble can change per edge
                    if (dcnt_ff == 5'h00) begin
                        state_ff <= ST_DATA;
                    end else if (sck_rise || sck_fall) begin
                        dcnt_ff <= dcnt_ff - 5'h01;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // lane drivers and read address; the next byte is prefetched at the
    // rising edge so the array read is done long before the falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_ff    <= '0;
            byte_ff    <= 8'h00;
            io_out_ff  <= 4'h0;
            io_oe_n_ff <= 4'hF;
        end else if (cs_rise || cs_fall) begin
            io_oe_n_ff <= 4'hF;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (addr_take && cnt_ff == addr_last) begin
                        addr_ff <= nxt_ash[ADDR_W-1:0];
                    end
                end
                ST_DUMMY: begin
                    if (dcnt_ff == 5'h00) begin
                        byte_ff    <= mem_rd;
                        io_out_ff  <= mem_rd[7:4];
                        io_oe_n_ff <= 4'h0;
                    end else if (train_en && dcnt_ff <= TRAIN_EDGES) begin
                        io_out_ff  <= {4{pat_bit}};
                        io_oe_n_ff <= 4'h0;
                    end else begin
                        io_oe_n_ff <= 4'hF;
                    end
                end
                ST_DATA: begin
                    if (sck_rise) begin
                        io_out_ff <= byte_ff[3:0];
                        addr_ff   <= addr_ff + ADDR_W'(1);
                    end else if (sck_fall) begin
                        byte_ff   <= mem_rd;
                        io_out_ff <= mem_rd[7:4];
                    end
                end
                default: begin
                    io_oe_n_ff <= 4'hF;
                end
            endcase
        end
    end

    dqr_mem #(
        .AW (ADDR_W),
        .DW (8)
    ) u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (mem_we_ff),
        .wr_addr (mem_wa_ff),
        .wr_data (mem_wd_ff),
        .rd_addr (addr_ff),
        .rd_data (mem_rd)
    );

    // write address and data channels, taken in either order
    assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            awready_ff <= 1'b0;
            awaddr_ff  <= '0;
            w_got_ff   <= 1'b0;
            wready_ff  <= 1'b0;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (awvalid && awready_ff) begin
                aw_got_ff  <= 1'b1;
                awaddr_ff  <= awaddr;
                awready_ff <= 1'b0;
            end else if (wr_fire) begin
                aw_got_ff <= 1'b0;
            end else if (!aw_got_ff) begin
                awready_ff <= 1'b1;
            end
            if (wvalid && wready_ff) begin
                w_got_ff  <= 1'b1;
                wdata_ff  <= wdata;
                wstrb_ff  <= wstrb;
                wready_ff <= 1'b0;
            end else if (wr_fire) begin
                w_got_ff <= 1'b0;
            end else if (!w_got_ff) begin
                wready_ff <= 1'b1;
            end
        end
    end

    // write response; unmapped offsets answer with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= dqr_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // configuration registers and the array loading port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg1_ff   <= CFG1_RST;
            cfg2_ff   <= CFG2_RST;
            cfg3_ff   <= CFG3_RST;
            pat_ff    <= PAT_RST;
            ptr_ff    <= '0;
            mem_we_ff <= 1'b0;
            mem_wa_ff <= '0;
            mem_wd_ff <= 8'h00;
        end else begin
            mem_we_ff <= 1'b0;
            if (wr_fire) begin
                if (awaddr_ff == OFF_CFG1) begin
                    cfg1_ff <= dqr_merge(cfg1_ff, wdata_ff, wstrb_ff);
                end else if (awaddr_ff == OFF_CFG2) begin
                    cfg2_ff <= dqr_merge(cfg2_ff, wdata_ff, wstrb_ff);
                end else if (awaddr_ff == OFF_CFG3) begin
                    cfg3_ff <= dqr_merge(cfg3_ff, wdata_ff, wstrb_ff);
                end else if (awaddr_ff == OFF_PAT) begin
                    pat_ff <= dqr_merge(pat_ff, wdata_ff, wstrb_ff);
                end else if (awaddr_ff == OFF_PTR) begin
                    ptr_ff <= wdata_ff[ADDR_W-1:0];
                end else if (awaddr_ff == OFF_WDAT && wstrb_ff[0]) begin
                    mem_we_ff <= 1'b1;
                    mem_wa_ff <= ptr_ff;
                    mem_wd_ff <= wdata_ff[7:0];
                    ptr_ff    <= ptr_ff + ADDR_W'(1);
                end
            end
        end
    end

    // read decode; the loading port reads back as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (araddr == OFF_CFG1) begin
            rd_mux[7:0] = cfg1_ff;
        end else if (araddr == OFF_CFG2) begin
            rd_mux[7:0] = cfg2_ff;
        end else if (araddr == OFF_CFG3) begin
            rd_mux[7:0] = cfg3_ff;
        end else if (araddr == OFF_PAT) begin
            rd_mux[7:0] = pat_ff;
        end else if (araddr == OFF_PTR) begin
            rd_mux[ADDR_W-1:0] = ptr_ff;
        end else if (araddr == OFF_STAT) begin
            rd_mux[7:0] = {~cs_s_ff, mode_done_ff, pend_ff, cont_ff, 1'b0, state_ff};
        end else if (araddr == OFF_ADDR) begin
            rd_mux[ADDR_W-1:0] = addr_ff;
        end
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux;
            rresp_ff   <= dqr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else begin
            if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
            end
            if (!rvalid_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    assign awready = awready_ff;
    assign wready  = wready_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = arready_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign io_out  = io_out_ff;
    assign io_oe_n = io_oe_n_ff;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_cmd_to_addr;
        state_ff == ST_CMD ##1 state_ff == ST_ADDR;
    endsequence
    sequence s_addr_to_mode;
        state_ff == ST_ADDR ##1 state_ff == ST_MODE;
    endsequence
    sequence s_mode_to_dummy;
        state_ff == ST_MODE ##1 state_ff == ST_DUMMY;
    endsequence

    a_read_gated: assert property (s_cmd_to_addr |-> $past(quad_en))
        else $error("read taken without quad enable");
    a_addr_length: assert property (s_addr_to_mode |->
        $past(cnt_ff) == ($past(a4_ff) ? 4'h7 : 4'h5))
        else $error("wrong address length");
    a_addr_falling: assert property (state_ff == ST_ADDR && sck_fall && !cs_rise && !cs_fall
        && cnt_ff != 4'h0 && cnt_ff != addr_last |=> cnt_ff == $past(cnt_ff) + 4'h1)
        else $error("falling edge nibble missed");
    a_data_driven: assert property (state_ff == ST_DATA |-> io_oe_n_ff == 4'h0)
        else $error("lanes not driven in data");
    a_dummy_count: assert property (s_mode_to_dummy |-> dcnt_ff == {1'b0, lat} << 1)
        else $error("dummy count wrong");
    a_cont_enter: assert property (cs_rise && mode_done_ff && pend_ff |=> cont_ff)
        else $error("continuous mode not entered");
    a_cont_skip: assert property (cs_fall && !cs_rise && cont_ff |=> state_ff == ST_ADDR)
        else $error("opcode not skipped");
    a_cont_leave: assert property (cs_rise && mode_done_ff && !pend_ff |=> !cont_ff)
        else $error("continuous mode not left");
    a_mode_reset: assert property (state_ff == ST_CMD && sck_rise && !cs_rise && !cs_fall
        && cnt_ff == cmd_last && nxt_cmd == OP_MODE_RST |=> !cont_ff)
        else $error("mode reset ignored");
    a_addr_step: assert property (state_ff == ST_DATA && sck_rise && !cs_rise && !cs_fall
        |=> addr_ff == $past(addr_ff) + ADDR_W'(1))
        else $error("address did not step");
    a_addr_wrap: assert property (state_ff == ST_DATA && sck_rise && !cs_rise && !cs_fall
        && (&addr_ff) |=> addr_ff == '0)
        else $error("address did not wrap");
    a_preamble_bit: assert property (state_ff == ST_DUMMY && train_en && dcnt_ff != 5'h00
        && dcnt_ff <= TRAIN_EDGES && !cs_rise && !cs_fall
        |=> io_oe_n_ff == 4'h0 && io_out_ff == {4{$past(pat_bit)}})
        else $error("preamble bit wrong");
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import dqr_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, sck, sel_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  io_in, io_out, io_oe_n;
    int          n_errors = 0;
    int          n_tests = 0;
    dqr_top #(.ADDR_W(10)) dqr_top_i (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sck, .sel_n,
        .io_in, .io_out, .io_oe_n);
    dqr_host dqr_host_i (.aclk, .sck, .sel_n, .io_in, .io_out, .io_oe_n);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ready sampled 1 ns after the edge, so the handshake never races;
    // answer watched in the same loop, rvalid lasts only one cycle here
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic a_ok, w_ok, r_ok;
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        do begin
            #1;
            a_ok = awvalid & awready | arvalid & arready;
            w_ok = wvalid & wready;
            r_ok = bvalid & bready | rvalid & rready;
            {rd, rs} = {rdata, w ? bresp : rresp};
            @(posedge aclk);
            if (a_ok) {awvalid, arvalid} <= 2'h0;
            if (w_ok) wvalid <= 1'b0;
        end while (!r_ok);
        // one idle edge so a following call never drives bready twice at once
        {bready, rready} <= 2'h0;
        @(posedge aclk);
    endtask
    // array byte at a is a[7:0] ^ 5A
    task automatic chk_data(input int lat, input logic [9:0] a, input int nb);
        int         k;
        int         i;
        logic [7:0] e;
        for (k = 0; k < nb; k++) begin
            i = dqr_host_i.dbase + 2 * (lat + k);
            e = {dqr_host_i.sq[i], dqr_host_i.sq[i+1]};
            chk("data", 32'(e), 32'(8'(a + k) ^ 8'h5A));
        end
    endtask
    task automatic t_regs();
        int k;
        axi(1'b0, OFF_PAT, 32'h0);
        chk("pattern reset", rd, 32'h34);
        axi(1'b0, 8'h40, 32'h0);
        chk("unmapped resp", 32'(rs), 32'(RESP_SLVERR));
        for (k = 0; k < 4; k++) begin
            axi(1'b1, OFF_PTR, 32'(10'(10'h3FE + k)));
            axi(1'b1, OFF_WDAT, 32'(8'(10'h3FE + k) ^ 8'h5A));
            chk("write resp", 32'(rs), 32'(RESP_OKAY));
        end
    endtask
    task automatic t_refuse();
        dqr_host_i.frame(1'b1, 1'b0, OP_READ3, 32'h3FE, 6, 8'h00, 2, 2);
        foreach (dqr_host_i.oq[k]) chk("refused", 32'(dqr_host_i.oq[k]), 32'hF);
    endtask
    task automatic t_read3();
        int k;
        axi(1'b1, OFF_CFG1, 32'h2);
        axi(1'b1, OFF_CFG3, 32'h2);
        dqr_host_i.frame(1'b1, 1'b0, OP_READ3, 32'h3FE, 6, 8'h00, 2, 4);
        for (k = 0; k < 4; k++)
            chk("dummy", 32'(dqr_host_i.oq[dqr_host_i.dbase + k]), 32'hF);
        chk_data(2, 10'h3FE, 4);
    endtask
    // four-wire opcode, 4-byte address, preamble, then continuous entry and exit
    task automatic t_cont();
        logic [7:0] pat;
        int         j;
        int         i;
        pat = 8'h6C;
        axi(1'b1, OFF_CFG1, 32'h0);
        axi(1'b1, OFF_CFG2, 32'h9);
        axi(1'b1, OFF_CFG3, 32'h14);
        axi(1'b1, OFF_PAT, 32'(pat));
        dqr_host_i.frame(1'b1, 1'b1, OP_READ3, 32'h3FF, 8, 8'h5A, 4, 2);
        for (j = 0; j < 8; j++) begin
            i = dqr_host_i.dbase + j;
            chk("preamble", {dqr_host_i.oq[i], dqr_host_i.sq[i]}, {4'h0, {4{pat[7-j]}}});
        end
        chk_data(4, 10'h3FF, 2);
        axi(1'b0, OFF_STAT, 32'h0);
        chk("cont set", 32'(rd[4]), 32'h1);
        dqr_host_i.frame(1'b0, 1'b1, 8'h00, 32'h1, 8, 8'h00, 4, 1);
        chk_data(4, 10'h1, 1);
        axi(1'b0, OFF_STAT, 32'h0);
        chk("cont left", 32'(rd[4]), 32'h0);
        // length bit cleared, so four address bytes come from the opcode alone
        axi(1'b1, OFF_CFG2, 32'h8);
        dqr_host_i.frame(1'b1, 1'b1, OP_READ4, 32'h3FE, 8, 8'h00, 4, 1);
        chk_data(4, 10'h3FE, 1);
        dqr_host_i.frame(1'b1, 1'b1, OP_MODE_RST, 32'h0, 0, 8'h00, 0, 0);
        axi(1'b0, OFF_STAT, 32'h0);
        chk("mode reset", 32'(rd[4]), 32'h0);
    endtask
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        t_regs();
        t_refuse();
        t_read3();
        t_cont();
        conclude();
    end
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
